// ### hdl/rcs_pkg.sv
package rcs_pkg;

  // Counter width for measured reference periods, in MCLK cycles
  localparam int RCS_CNT_W = 16;

  // Low time that flags a lost input, in measured periods
  localparam int RCS_LOSS_PERIODS = 2;

  // AXI4-Lite
  localparam int RCS_ADDR_W = 8;
  localparam int RCS_DATA_W = 32;
  localparam logic [1:0] RCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] RCS_RESP_SLVERR = 2'h2;

  // Register byte addresses
  localparam logic [RCS_ADDR_W-1:0] RCS_REG_CTRL = 8'h00;
  localparam logic [RCS_ADDR_W-1:0] RCS_REG_STATUS = 8'h04;
  localparam logic [RCS_ADDR_W-1:0] RCS_REG_PERIOD_A = 8'h08;
  localparam logic [RCS_ADDR_W-1:0] RCS_REG_PERIOD_B = 8'h0c;

  // Control fields
  localparam int RCS_CTRL_AUTO_BIT = 0;
  localparam int RCS_CTRL_SWAP_BIT = 1;
  localparam logic RCS_CTRL_AUTO_RST = 1'b1;

  // Status fields
  localparam int RCS_ST_LOSS_A_BIT = 0;
  localparam int RCS_ST_LOSS_B_BIT = 1;
  localparam int RCS_ST_ACTIVE_BIT = 2;
  localparam int RCS_ST_GATED_BIT = 3;
  localparam int RCS_ST_STATE_LSB = 4;

  // Selection codes: low is input A, high is input B
  localparam logic RCS_SEL_A = 1'b0;
  localparam logic RCS_SEL_B = 1'b1;

  // Switchover sequence RUN -> WAIT -> GATED -> RUN, one bit per step except GATED -> RUN
  typedef enum logic [1:0] {
    RCS_ST_RUN = 2'h0,
    RCS_ST_WAIT = 2'h1,
    RCS_ST_GATED = 2'h3
  } rcs_state_t;

  // One-cycle falling edge of a sampled level
  function automatic logic rcs_fall(input logic prev, input logic cur);
    return prev & ~cur;
  endfunction

  // One-cycle rising edge of a sampled level
  function automatic logic rcs_rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction

endpackage

// ### hdl/rcs_loss_sense.sv
`timescale 1ns/10ps
module rcs_loss_sense
  import rcs_pkg::*;
#(
  parameter int CNT_W = RCS_CNT_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sample,
  output logic loss,
  output logic [CNT_W-1:0] period
);

  logic prev;
  logic armed;
  logic [CNT_W-1:0] per_cnt;
  logic [CNT_W:0] low_cnt;

  wire rise = rcs_rise(prev, sample);
  wire per_max = &per_cnt;
  wire low_max = &low_cnt;
  wire [CNT_W:0] low_limit = (CNT_W+1)'(period) * (CNT_W+1)'(RCS_LOSS_PERIODS);
  wire limit_hit = (period != '0) && !sample && (low_cnt >= low_limit);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // High, so a level already high at release is not taken as a rise
      prev <= 1'b1;
      armed <= 1'b0;
      per_cnt <= '0;
      low_cnt <= '0;
      period <= '0;
      loss <= 1'b0;
    end else begin
      prev <= sample;
      per_cnt <= rise ? '0 : (per_max ? per_cnt : per_cnt + 1'b1);
      armed <= armed | rise;
      // Span up to the first rise is partial; that rise only arms
      if (rise && armed) begin
        period <= per_max ? per_cnt : per_cnt + 1'b1;
      end
      low_cnt <= sample ? '0 : (low_max ? low_cnt : low_cnt + 1'b1);
      if (rise) begin
        loss <= 1'b0; // [R11]
      end else if (limit_hit) begin
        loss <= 1'b1; // [R01]
      end
    end
  end

  chk_loss_after_low: assert property (@(posedge mclk) disable iff (rst) // [R01]
    limit_hit && !rise |=> loss)
    else $error("loss flag not raised after long low time");

  chk_loss_release: assert property (@(posedge mclk) disable iff (rst) // [R11]
    rise |=> !loss)
    else $error("loss flag kept after input toggled again");

  chk_loss_only_low: assert property (@(posedge mclk) disable iff (rst) // [R01]
    $rose(loss) |-> !$past(sample, 2) && ($past(period) != '0))
    else $error("loss flag raised while input was not low");

endmodule // rcs_loss_sense

// ### hdl/rcs_top.sv
// Behaviour
// [R01] Input A low for about two measured periods raises its loss flag.
// [R02] Loss of current input with auto enabled switches selection to the other.
// [R03] Switchover steps occur on falling edges of an input still running. A lost current input is gated at once, with no falling edge.
// [R04] Manual swap request is honoured even while automatic switchover is on.
// [R05] Manual sequence starts on swap request rising edge with both inputs running.
// [R06] Controller holds swap request high three periods of the slower input.
// [R07] Leaving an input, output is gated off on that input's next falling edge.
// [R08] After gating, selection moves to the new input on its next falling edge.
// [R09] Active indicator follows the multiplexer source as it changes.
// [R10] Active indicator low for input A, high for input B.
// [R11] Input B has same loss flag; flags drop once input toggles again.
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module rcs_top
  import rcs_pkg::*;
#(
  parameter int CNT_W = RCS_CNT_W
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic REF_INPUT_A,
  input wire logic REF_INPUT_B,
  input wire logic SWAP_REQ,
  output logic REF_OUT,
  output logic ACTIVE,
  output logic LOSS_FLAG_A,
  output logic LOSS_FLAG_B,
  input wire logic [RCS_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [RCS_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [RCS_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [RCS_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // Loss sensing per input
  logic loss_a;
  logic loss_b;
  logic [CNT_W-1:0] period_a;
  logic [CNT_W-1:0] period_b;

  rcs_loss_sense #(.CNT_W(CNT_W)) u_sense_a (
    .mclk(MCLK),
    .rst(RST),
    .sample(REF_INPUT_A),
    .loss(loss_a),
    .period(period_a)
  );

  rcs_loss_sense #(.CNT_W(CNT_W)) u_sense_b (
    .mclk(MCLK),
    .rst(RST),
    .sample(REF_INPUT_B),
    .loss(loss_b),
    .period(period_b)
  );

  // Switchover state
  rcs_state_t state;
  rcs_state_t next_state;
  logic sel;
  logic gated;
  logic prev_a;
  logic prev_b;
  logic prev_swap;
  logic auto_en;
  logic sw_swap;

  wire fall_a = rcs_fall(prev_a, REF_INPUT_A);
  wire fall_b = rcs_fall(prev_b, REF_INPUT_B);
  wire swap_rise = rcs_rise(prev_swap, SWAP_REQ) | sw_swap;
  wire cur_fall = (sel == RCS_SEL_B) ? fall_b : fall_a;
  wire alt_fall = (sel == RCS_SEL_B) ? fall_a : fall_b;
  wire cur_loss = (sel == RCS_SEL_B) ? loss_b : loss_a;
  wire alt_loss = (sel == RCS_SEL_B) ? loss_a : loss_b;
  wire cur_level = (sel == RCS_SEL_B) ? REF_INPUT_B : REF_INPUT_A;
  wire auto_trig = auto_en && cur_loss && !alt_loss; // [R02]
  wire manual_trig = swap_rise && !loss_a && !loss_b; // [R04] [R05]
  wire start = (state == RCS_ST_RUN) && (auto_trig || manual_trig);
  // A dead current input has no falling edge left; gate at once then
  wire gate_now = (state == RCS_ST_WAIT) && (cur_fall || cur_loss); // [R07] [R03]
  wire switch_now = (state == RCS_ST_GATED) && alt_fall; // [R08] [R03]

  always_comb begin
    next_state = state;
    case (state)
      RCS_ST_RUN: begin
        if (start) begin
          next_state = RCS_ST_WAIT;
        end
      end
      RCS_ST_WAIT: begin
        if (gate_now) begin
          next_state = RCS_ST_GATED;
        end
      end
      RCS_ST_GATED: begin
        if (switch_now) begin
          next_state = RCS_ST_RUN;
        end
      end
      default: begin
        next_state = RCS_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= RCS_ST_RUN;
      sel <= RCS_SEL_A;
      gated <= 1'b0;
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      prev_swap <= 1'b0;
    end else begin
      state <= next_state;
      prev_a <= REF_INPUT_A;
      prev_b <= REF_INPUT_B;
      prev_swap <= SWAP_REQ;
      if (gate_now) begin
        gated <= 1'b1; // [R07]
      end else if (switch_now) begin
        gated <= 1'b0;
        sel <= ~sel; // [R08] [R02]
      end
    end
  end

  // Outputs, all registered
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      REF_OUT <= 1'b0;
      ACTIVE <= RCS_SEL_A;
      LOSS_FLAG_A <= 1'b0;
      LOSS_FLAG_B <= 1'b0;
    end else begin
      REF_OUT <= !gated && !gate_now && !switch_now && cur_level; // [R07]
      ACTIVE <= switch_now ? ~sel : sel; // [R09] [R10]
      LOSS_FLAG_A <= loss_a; // [R01]
      LOSS_FLAG_B <= loss_b; // [R11]
    end
  end

  // AXI4-Lite write path
  logic [RCS_ADDR_W-1:0] aw_addr;
  logic [RCS_DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  wire do_write = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
  wire wr_ctrl = do_write && (aw_addr == RCS_REG_CTRL) && w_strb[0];
  wire wr_known = (aw_addr == RCS_REG_CTRL) || (aw_addr == RCS_REG_STATUS) ||
                  (aw_addr == RCS_REG_PERIOD_A) || (aw_addr == RCS_REG_PERIOD_B);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RCS_RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_known ? RCS_RESP_OKAY : RCS_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY <= 1'b1;
      end
    end
  end

  // Control register; the swap bit is a self-clearing request
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      auto_en <= RCS_CTRL_AUTO_RST;
      sw_swap <= 1'b0;
    end else begin
      sw_swap <= wr_ctrl && w_data[RCS_CTRL_SWAP_BIT]; // [R04]
      if (wr_ctrl) begin
        auto_en <= w_data[RCS_CTRL_AUTO_BIT];
      end
    end
  end

  // AXI4-Lite read path
  logic [RCS_DATA_W-1:0] rd_mux;
  logic rd_known;

  always_comb begin
    rd_mux = '0;
    rd_known = 1'b1;
    case (S_AXI_ARADDR)
      RCS_REG_CTRL: begin
        rd_mux[RCS_CTRL_AUTO_BIT] = auto_en;
      end
      RCS_REG_STATUS: begin
        rd_mux[RCS_ST_LOSS_A_BIT] = loss_a;
        rd_mux[RCS_ST_LOSS_B_BIT] = loss_b;
        rd_mux[RCS_ST_ACTIVE_BIT] = sel;
        rd_mux[RCS_ST_GATED_BIT] = gated;
        rd_mux[RCS_ST_STATE_LSB +: 2] = state;
      end
      RCS_REG_PERIOD_A: begin
        rd_mux[CNT_W-1:0] = period_a;
      end
      RCS_REG_PERIOD_B: begin
        rd_mux[CNT_W-1:0] = period_b;
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RCS_RESP_OKAY;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_known ? RCS_RESP_OKAY : RCS_RESP_SLVERR;
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Checks
  sequence s_gate_step;
    (state == RCS_ST_WAIT) && cur_fall;
  endsequence

  sequence s_switch_step;
    (state == RCS_ST_GATED) && alt_fall;
  endsequence

  chk_auto_start: assert property (@(posedge MCLK) disable iff (RST) // [R02]
    (state == RCS_ST_RUN) && auto_trig |=> (state == RCS_ST_WAIT))
    else $error("automatic switchover did not start on loss");
  chk_manual_start: assert property (@(posedge MCLK) disable iff (RST) // [R05]
    (state == RCS_ST_RUN) && rcs_rise(prev_swap, SWAP_REQ) && !loss_a && !loss_b
      |=> (state == RCS_ST_WAIT))
    else $error("manual swap request not honoured");
  chk_gate_on_fall: assert property (@(posedge MCLK) disable iff (RST) // [R07]
    s_gate_step |=> gated ##1 !REF_OUT)
    else $error("output not gated on falling edge of current input");
  chk_switch_on_fall: assert property (@(posedge MCLK) disable iff (RST) // [R08]
    s_switch_step |=> (sel != $past(sel)) && !gated && (state == RCS_ST_RUN))
    else $error("selection did not move on falling edge of new input");
  chk_sel_only_fall: assert property (@(posedge MCLK) disable iff (RST) // [R03]
    $changed(sel) |-> ($past(state) == RCS_ST_GATED) && $past(alt_fall))
    else $error("selection changed without a falling edge");
  chk_active_tracks: assert property (@(posedge MCLK) disable iff (RST) // [R09] [R10]
    ##1 (ACTIVE == sel))
    else $error("active indicator does not match selected input");
  chk_gated_quiet: assert property (@(posedge MCLK) disable iff (RST) // [R07]
    gated [*2] |-> !REF_OUT)
    else $error("reference output toggled while gated");
  chk_loss_mirror: assert property (@(posedge MCLK) disable iff (RST) // [R01]
    $rose(loss_a) |=> LOSS_FLAG_A ##0 !$past(LOSS_FLAG_A))
    else $error("loss flag output does not follow sensing");

  chk_bvalid_hold: assert property (@(posedge MCLK) disable iff (RST)
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped before accepted");

endmodule // rcs_top

// ### dv/rcs_ref_src.sv
`timescale 1ns/10ps
module rcs_ref_src (
  input wire logic mclk,
  input wire logic run,
  input wire logic [7:0] half,
  output logic ref_o
);
  logic [7:0] cnt;
  initial begin
    ref_o = 1'b0;
    cnt = 8'h00;
  end
  // Stopped source parks low, like a dead oscillator
  always @(posedge mclk) begin
    if (!run) begin
      ref_o <= 1'b0;
      cnt <= 8'h00;
    end else if (cnt == half - 8'h01) begin
      ref_o <= ~ref_o;
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule // rcs_ref_src

// ### dv/rcs_top_bench.sv
`timescale 1ns/10ps
module rcs_top_bench;
  import rcs_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} rcs_row_t;
  logic mclk, rst, swap, run_a, run_b, ref_a, ref_b, ref_out, active, loss_a, loss_b, prev;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  int fails, n_checks;
  rcs_row_t rows[6];

  rcs_ref_src src_a (.mclk(mclk), .run(run_a), .half(8'h04), .ref_o(ref_a));
  rcs_ref_src src_b (.mclk(mclk), .run(run_b), .half(8'h05), .ref_o(ref_b));

  rcs_top DUT (.MCLK(mclk), .RST(rst), .REF_INPUT_A(ref_a), .REF_INPUT_B(ref_b), .SWAP_REQ(swap),
    .REF_OUT(ref_out), .ACTIVE(active), .LOSS_FLAG_A(loss_a), .LOSS_FLAG_B(loss_b),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic guard(input logic ok);
    chk({31'h0, ok}, 32'h1);
    if (ok !== 1'b1) begin
      finish_test();
    end
  endtask

  task automatic wait_out(input int s, input logic v);
    int n;
    logic [2:0] o;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      o = {loss_b, loss_a, active};
    end while (o[s] !== v && n < 300);
    guard(o[s] === v);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while ((aw || w) && n < 50) begin
      @(posedge mclk);
      n++;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    guard(!aw && !w);
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    guard(bvalid === 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (arready !== 1'b1 && n < 50);
    guard(arready === 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    guard(rvalid === 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    fails = 0;
    n_checks = 0;
    {rst, run_a, run_b} = 3'h7;
    {swap, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    rows = '{'{8'h00, 32'h1, RCS_RESP_OKAY}, '{8'h04, 32'h0, RCS_RESP_OKAY},
      '{8'h08, 32'h8, RCS_RESP_OKAY}, '{8'h0c, 32'ha, RCS_RESP_OKAY},
      '{8'h10, 32'h0, RCS_RESP_SLVERR}, '{8'hfc, 32'h0, RCS_RESP_SLVERR}};
    repeat (16) @(posedge mclk);
    chk({ref_out, active, loss_a, loss_b}, 32'h0);
    rst <= 1'b0;
    repeat (40) @(posedge mclk);
    foreach (rows[i]) begin
      axi_rd(rows[i].a);
      chk(rd, rows[i].d);
      chk(rsp, rows[i].r);
    end
    axi_wr(8'h10, 32'h0, 4'hf);
    chk(rsp, RCS_RESP_SLVERR);
    // Manual swap A to B, request held well past three slow periods
    swap <= 1'b1;
    wait_out(0, 1'b1);
    chk({ref_out, ref_b}, 32'h0);
    repeat (30) @(posedge mclk);
    swap <= 1'b0;
    repeat (12) begin
      prev = ref_b;
      @(posedge mclk);
      chk(ref_out, prev);
    end
    axi_rd(RCS_REG_STATUS);
    chk(rd, 32'h4);
    // Current input dies: automatic return to A, then A dies: automatic move to B
    run_b <= 1'b0;
    wait_out(2, 1'b1);
    wait_out(0, 1'b0);
    chk(loss_a, 32'h0);
    run_b <= 1'b1;
    wait_out(2, 1'b0);
    run_a <= 1'b0;
    wait_out(1, 1'b1);
    wait_out(0, 1'b1);
    axi_rd(RCS_REG_STATUS);
    chk(rd, 32'h5);
    run_a <= 1'b1;
    wait_out(1, 1'b0);
    // Auto off, input lost, request ignored
    axi_wr(RCS_REG_CTRL, 32'h0, 4'hf);
    run_b <= 1'b0;
    wait_out(2, 1'b1);
    swap <= 1'b1;
    repeat (40) @(posedge mclk);
    swap <= 1'b0;
    chk(active, 32'h1);
    run_b <= 1'b1;
    wait_out(2, 1'b0);
    axi_wr(RCS_REG_CTRL, 32'h2, 4'hf);
    wait_out(0, 1'b0);
    axi_rd(RCS_REG_CTRL);
    chk(rd, 32'h0);
    // Control write with its low strobe clear is ignored
    axi_wr(RCS_REG_CTRL, 32'h1, 4'h0);
    chk(rsp, RCS_RESP_OKAY);
    axi_rd(RCS_REG_CTRL);
    chk(rd, 32'h0);
    // Reset in mid-run: defaults back, no false loss or swap after release
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({ref_out, active, loss_a, loss_b}, 32'h0);
    rst <= 1'b0;
    repeat (60) @(posedge mclk);
    chk({active, loss_a, loss_b}, 32'h0);
    axi_rd(RCS_REG_CTRL);
    chk(rd, 32'h1);
    finish_test();
  end
endmodule // rcs_top_bench
